/* hdl/ilc_defs.svh */
// Register offsets, reset values and line masks of the I/O line control bank
`ifndef ILC_DEFS_SVH
`define ILC_DEFS_SVH

// Register byte offsets
`define ILC_OFF_OWNER_SET 8'h00
`define ILC_OFF_OWNER_CLR 8'h04
`define ILC_OFF_OWNER_STS 8'h08
`define ILC_OFF_OE_SET 8'h10
`define ILC_OFF_OE_CLR 8'h14
`define ILC_OFF_OE_STS 8'h18
`define ILC_OFF_FILT_SET 8'h20
`define ILC_OFF_FILT_CLR 8'h24
`define ILC_OFF_FILT_STS 8'h28
`define ILC_OFF_DATA_SET 8'h30
`define ILC_OFF_DATA_CLR 8'h34
`define ILC_OFF_DATA_STS 8'h38
`define ILC_OFF_PIN_STS 8'h3C
`define ILC_OFF_IRQ_SET 8'h40
`define ILC_OFF_IRQ_CLR 8'h44
`define ILC_OFF_IRQ_MASK 8'h48
`define ILC_OFF_IRQ_STS 8'h4C
`define ILC_OFF_PERMIT_SET 8'hA0
`define ILC_OFF_PERMIT_CLR 8'hA4
`define ILC_OFF_PERMIT_STS 8'hA8

// Reset values and masks
`define ILC_WORD_ZERO 32'h0000_0000
`define ILC_WORD_ONES 32'hFFFF_FFFF
`define ILC_OWNER_RESET 32'hFFFF_FFFF
`define ILC_LINE_MASK 32'hFFFF_FFFF

`endif

/* hdl/ilc_pkg.sv */
// Types shared by the I/O line control bank files
package ilc_pkg;
    typedef logic [31:0] ilc_word_t;
    typedef logic [7:0] ilc_addr_t;
endpackage

/* hdl/ilc_line_sync.sv */
// One I/O line input path: three-flop synchroniser and optional glitch filter
`timescale 1ns/1ps
module ilc_line_sync (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Line input and control
    input wire logic raw_in,
    input wire logic filter_en_in,
    // Cleaned level and change pulse
    output logic level_out,
    output logic change_out
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic hold_reg;
    logic level_reg;
    logic agree;
    logic take;

    // Stage two and three must agree; the filter also wants a third matching sample
    assign agree = (sync2_reg == sync3_reg);
    assign take = agree && (!filter_en_in || (sync3_reg == hold_reg));

    // Synchroniser chain, first stage read only by the second
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            hold_reg <= 1'b0;
            level_reg <= 1'b0;
            change_out <= 1'b0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            hold_reg <= sync3_reg;
            level_reg <= take ? sync3_reg : level_reg;
            change_out <= take && (sync3_reg != level_reg);
        end
    end

    assign level_out = level_reg;

endmodule // ilc_line_sync

/* hdl/ilc_bank.sv */
// I/O line control bank: per-line ownership, drive, filter, data and change interrupt registers
//
// Behaviour
// - ownership status reads 1 when controller owns
// - output-enable set write of 1 enables driver
// - output-enable clear write of 1 disables driver
// - output-enable status reads 1 when driving
// - filter set write of 1 enables filter
// - filter clear write of 1 disables filter
// - filter status reads 1 while filter enabled
// - data set write of 1 makes line 1
// - data clear write of 1 makes line 0
// - data status returns scheduled drive value
// - data status always readable, writable when permitted
// - pin level status returns actual line level
// - irq enable set write of 1 enables
// - irq enable clear write of 1 disables
// - irq mask reads 1 when change irq enabled
// - data status bit writable only when permitted
// - change status sets on change, clears on read
// - ownership set/clear hands line controller/peripheral
// - 32 bits, undefined lines ignored, read zero
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "ilc_defs.svh"
module ilc_bank #(
    parameter logic [31:0] LINE_MASK = `ILC_LINE_MASK,
    parameter logic [31:0] OWNER_RESET = `ILC_OWNER_RESET
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Register port
    input wire ilc_pkg::ilc_addr_t reg_addr_in,
    input wire ilc_pkg::ilc_word_t reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output ilc_pkg::ilc_word_t reg_rdata_out,
    // Package pins
    input wire ilc_pkg::ilc_word_t pin_level_in,
    output ilc_pkg::ilc_word_t pin_data_out,
    output ilc_pkg::ilc_word_t pin_oe_n_out,
    // Multiplexed peripherals
    input wire ilc_pkg::ilc_word_t periph_data_in,
    input wire ilc_pkg::ilc_word_t periph_oe_in,
    output ilc_pkg::ilc_word_t periph_level_out,
    // Interrupt
    output logic irq_out
);
    import ilc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Exact match of a register offset, shared by write and read decode
    function automatic logic ilc_hit(input ilc_addr_t addr, input ilc_addr_t off);
        ilc_hit = (addr == off);
    endfunction

    // Write strobes, one per writable register offset, and the change status read strobe
    ilc_word_t wr_bits;
    logic wr_owner_set;
    logic wr_owner_clr;
    logic wr_oe_set;
    logic wr_oe_clr;
    logic wr_filt_set;
    logic wr_filt_clr;
    logic wr_data_set;
    logic wr_data_clr;
    logic wr_data_dir;
    logic wr_irq_set;
    logic wr_irq_clr;
    logic wr_permit_set;
    logic wr_permit_clr;
    logic rd_irq_sts;

    // Bits for undefined lines are dropped before any state sees them
    assign wr_bits = reg_wdata_in & LINE_MASK;
    assign wr_owner_set = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_OWNER_SET);
    assign wr_owner_clr = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_OWNER_CLR);
    assign wr_oe_set = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_OE_SET);
    assign wr_oe_clr = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_OE_CLR);
    assign wr_filt_set = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_FILT_SET);
    assign wr_filt_clr = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_FILT_CLR);
    assign wr_data_set = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_DATA_SET);
    assign wr_data_clr = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_DATA_CLR);
    assign wr_data_dir = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_DATA_STS);
    assign wr_irq_set = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_IRQ_SET);
    assign wr_irq_clr = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_IRQ_CLR);
    assign wr_permit_set = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_PERMIT_SET);
    assign wr_permit_clr = reg_wr_in && ilc_hit(reg_addr_in, `ILC_OFF_PERMIT_CLR);
    assign rd_irq_sts = reg_rd_in && ilc_hit(reg_addr_in, `ILC_OFF_IRQ_STS);

    ////////////////////////////////////////////////////////////////////////////////
    // Per-line state

    // Per-line state and its next values
    ilc_word_t owner_reg;
    ilc_word_t owner_next;
    ilc_word_t oe_reg;
    ilc_word_t oe_next;
    ilc_word_t filt_reg;
    ilc_word_t filt_next;
    ilc_word_t data_reg;
    ilc_word_t data_next;
    ilc_word_t imr_reg;
    ilc_word_t imr_next;
    ilc_word_t permit_reg;
    ilc_word_t permit_next;
    ilc_word_t isr_reg;
    ilc_word_t isr_next;
    ilc_word_t level;
    ilc_word_t change;

    // Ownership: set hands the line to the controller, clear to the peripheral
    assign owner_next = wr_owner_set ? (owner_reg | wr_bits) :
                        wr_owner_clr ? (owner_reg & ~wr_bits) : owner_reg;
    // Output driver enable
    assign oe_next = wr_oe_set ? (oe_reg | wr_bits) :
                     wr_oe_clr ? (oe_reg & ~wr_bits) : oe_reg;
    // Glitch filter enable
    assign filt_next = wr_filt_set ? (filt_reg | wr_bits) :
                       wr_filt_clr ? (filt_reg & ~wr_bits) : filt_reg;
    // Output data; a direct write only reaches lines whose permit bit is set
    assign data_next = wr_data_set ? (data_reg | wr_bits) :
                       wr_data_clr ? (data_reg & ~wr_bits) :
                       wr_data_dir ? ((data_reg & ~permit_reg) | (wr_bits & permit_reg)) :
                       data_reg;
    // Change interrupt mask
    assign imr_next = wr_irq_set ? (imr_reg | wr_bits) :
                      wr_irq_clr ? (imr_reg & ~wr_bits) : imr_reg;
    // Direct data write permission
    assign permit_next = wr_permit_set ? (permit_reg | wr_bits) :
                         wr_permit_clr ? (permit_reg & ~wr_bits) : permit_reg;
    // Read clears the change flags; a change in the same cycle still wins
    assign isr_next = (rd_irq_sts ? `ILC_WORD_ZERO : isr_reg) | (change & LINE_MASK);

    // Control flip-flops, one update per clock
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            owner_reg <= OWNER_RESET & LINE_MASK;
            oe_reg <= `ILC_WORD_ZERO;
            filt_reg <= `ILC_WORD_ZERO;
            data_reg <= `ILC_WORD_ZERO;
            imr_reg <= `ILC_WORD_ZERO;
            permit_reg <= `ILC_WORD_ZERO;
            isr_reg <= `ILC_WORD_ZERO;
        end else begin
            owner_reg <= owner_next;
            oe_reg <= oe_next;
            filt_reg <= filt_next;
            data_reg <= data_next;
            imr_reg <= imr_next;
            permit_reg <= permit_next;
            isr_reg <= isr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input path, one synchroniser and filter per line

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_line
            ilc_line_sync u_sync (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .raw_in(pin_level_in[gi]),
                .filter_en_in(filt_reg[gi]),
                .level_out(level[gi]),
                .change_out(change[gi])
            );
        end
    endgenerate

    // Peripherals see the same cleaned level as software
    assign periph_level_out = level & LINE_MASK;

    ////////////////////////////////////////////////////////////////////////////////
    // Pad drive

    // Drive selection and the pad registers
    ilc_word_t drive_en;
    ilc_word_t drive_data;
    ilc_word_t pin_data_reg;
    ilc_word_t pin_oe_n_reg;

    // Owner selects who drives; peripheral path bypasses the controller enables
    assign drive_en = ((owner_reg & oe_reg) | (~owner_reg & periph_oe_in)) & LINE_MASK;
    assign drive_data = (owner_reg & data_reg) | (~owner_reg & periph_data_in);

    // Registered pads cost one cycle but keep the pins glitch free
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_data_reg <= `ILC_WORD_ZERO;
            pin_oe_n_reg <= `ILC_WORD_ONES;
        end else begin
            pin_data_reg <= drive_data & LINE_MASK;
            pin_oe_n_reg <= ~drive_en;
        end
    end

    assign pin_data_out = pin_data_reg;
    assign pin_oe_n_out = pin_oe_n_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Read port and interrupt

    // Selected status word and its registered copy
    ilc_word_t rd_sel;
    ilc_word_t rdata_reg;

    // AND-OR read mux; unmapped and write-only offsets read zero
    assign rd_sel = ({32{ilc_hit(reg_addr_in, `ILC_OFF_OWNER_STS)}} & owner_reg) |
                    ({32{ilc_hit(reg_addr_in, `ILC_OFF_OE_STS)}} & oe_reg) |
                    ({32{ilc_hit(reg_addr_in, `ILC_OFF_FILT_STS)}} & filt_reg) |
                    ({32{ilc_hit(reg_addr_in, `ILC_OFF_DATA_STS)}} & data_reg) |
                    ({32{ilc_hit(reg_addr_in, `ILC_OFF_PIN_STS)}} & level) |
                    ({32{ilc_hit(reg_addr_in, `ILC_OFF_IRQ_MASK)}} & imr_reg) |
                    ({32{ilc_hit(reg_addr_in, `ILC_OFF_IRQ_STS)}} & isr_reg) |
                    ({32{ilc_hit(reg_addr_in, `ILC_OFF_PERMIT_STS)}} & permit_reg);

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= `ILC_WORD_ZERO;
        end else begin
            rdata_reg <= reg_rd_in ? (rd_sel & LINE_MASK) : `ILC_WORD_ZERO;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign irq_out = |(isr_reg & imr_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Register writes land as set or clear masks in the next cycle; then reads, change flags, irq and pad enable
    AST_OWNER_SET: assert property (wr_owner_set |=> ((owner_reg & $past(wr_bits)) == $past(wr_bits)))
        else $error("ownership set write did not take");
    AST_OWNER_CLR: assert property (wr_owner_clr |=> ((owner_reg & $past(wr_bits)) == 32'h0000_0000))
        else $error("ownership clear write did not take");
    AST_OE_SET: assert property (wr_oe_set |=> (oe_reg == ($past(oe_reg) | $past(wr_bits))))
        else $error("output enable set wrong");
    AST_OE_CLR: assert property (wr_oe_clr |=> (oe_reg == ($past(oe_reg) & ~$past(wr_bits))))
        else $error("output enable clear wrong");
    AST_FILT_SET: assert property (wr_filt_set |=> (filt_reg == ($past(filt_reg) | $past(wr_bits))))
        else $error("filter set wrong");
    AST_FILT_CLR: assert property (wr_filt_clr |=> (filt_reg == ($past(filt_reg) & ~$past(wr_bits))))
        else $error("filter clear wrong");
    AST_DATA_SET: assert property (wr_data_set |=> (data_reg == ($past(data_reg) | $past(wr_bits))))
        else $error("data set wrong");
    AST_DATA_CLR: assert property (wr_data_clr |=> (data_reg == ($past(data_reg) & ~$past(wr_bits))))
        else $error("data clear wrong");
    AST_DATA_PERMIT: assert property (wr_data_dir |=>
        ((data_reg & ~$past(permit_reg)) == ($past(data_reg) & ~$past(permit_reg))))
        else $error("direct data write reached a locked line");
    AST_IRQ_SET: assert property (wr_irq_set |=> ((imr_reg & $past(wr_bits)) == $past(wr_bits)))
        else $error("irq enable set wrong");
    AST_IRQ_CLR: assert property (wr_irq_clr |=> ((imr_reg & $past(wr_bits)) == 32'h0000_0000))
        else $error("irq enable clear wrong");
    AST_OE_READ: assert property ((reg_rd_in && ilc_hit(reg_addr_in, `ILC_OFF_OE_STS)) |=>
        (reg_rdata_out == $past(oe_reg)))
        else $error("output status read wrong");
    AST_MASK_READ: assert property ((reg_rd_in && ilc_hit(reg_addr_in, `ILC_OFF_IRQ_MASK)) |=>
        (reg_rdata_out == $past(imr_reg)))
        else $error("irq mask read wrong");
    AST_ISR_CLEAR: assert property ((rd_irq_sts && (change == 32'h0000_0000)) |=>
        (isr_reg == 32'h0000_0000))
        else $error("change status not cleared by read");
    AST_ISR_KEEP: assert property (((change & LINE_MASK) != 32'h0000_0000) |=>
        ((isr_reg & $past(change & LINE_MASK)) == $past(change & LINE_MASK)))
        else $error("input change lost");
    AST_IRQ_OUT: assert property (((change & imr_reg & LINE_MASK) != 32'h0000_0000 && !wr_irq_clr) |=>
        irq_out)
        else $error("interrupt not raised on enabled change");
    AST_PAD_OE: assert property (1'b1 |=> (pin_oe_n_out == ~$past(drive_en)))
        else $error("pad enable does not follow owner and enable");
    AST_UNDEF_READ: assert property ((reg_rdata_out & ~LINE_MASK) == 32'h0000_0000)
        else $error("undefined bit read nonzero");

    // Writes aimed elsewhere must leave each state group alone, and a direct data write must reach permitted lines
    AST_OWNER_HOLD: assert property ((!wr_owner_set && !wr_owner_clr) |=> $stable(owner_reg))
        else $error("ownership moved without a write");
    AST_OE_HOLD: assert property ((!wr_oe_set && !wr_oe_clr) |=> $stable(oe_reg))
        else $error("output enable moved without a write");
    AST_FILT_HOLD: assert property ((!wr_filt_set && !wr_filt_clr) |=> $stable(filt_reg))
        else $error("filter enable moved without a write");
    AST_DATA_HOLD: assert property ((!wr_data_set && !wr_data_clr && !wr_data_dir) |=>
        $stable(data_reg))
        else $error("output data moved without a write");
    AST_MASK_HOLD: assert property ((!wr_irq_set && !wr_irq_clr) |=> $stable(imr_reg))
        else $error("irq mask moved without a write");
    AST_PERMIT_HOLD: assert property ((!wr_permit_set && !wr_permit_clr) |=> $stable(permit_reg))
        else $error("write permit moved without a write");
    AST_DATA_DIRECT: assert property (wr_data_dir |=>
        ((data_reg & $past(permit_reg)) == $past(wr_bits & permit_reg)))
        else $error("direct data write missed a permitted line");

    // Status reads return the state held at the strobe
    AST_OWNER_READ: assert property ((reg_rd_in && ilc_hit(reg_addr_in, `ILC_OFF_OWNER_STS)) |=>
        (reg_rdata_out == $past(owner_reg)))
        else $error("ownership status read wrong");
    AST_FILT_READ: assert property ((reg_rd_in && ilc_hit(reg_addr_in, `ILC_OFF_FILT_STS)) |=>
        (reg_rdata_out == $past(filt_reg)))
        else $error("filter status read wrong");
    AST_DATA_READ: assert property ((reg_rd_in && ilc_hit(reg_addr_in, `ILC_OFF_DATA_STS)) |=>
        (reg_rdata_out == $past(data_reg)))
        else $error("data status read wrong");
    AST_PIN_READ: assert property ((reg_rd_in && ilc_hit(reg_addr_in, `ILC_OFF_PIN_STS)) |=>
        (reg_rdata_out == $past(level & LINE_MASK)))
        else $error("pin level read wrong");
    AST_ISR_READ: assert property (rd_irq_sts |=>
        (reg_rdata_out == $past(isr_reg)))
        else $error("change status read wrong");

    // Undefined lines hold no state and are never driven
    AST_UNDEF_STATE: assert property (
        ((owner_reg | oe_reg | filt_reg | data_reg | imr_reg | isr_reg) & ~LINE_MASK) == 32'h0000_0000)
        else $error("state held on an undefined line");
    AST_UNDEF_DRIVE: assert property ((~pin_oe_n_out & ~LINE_MASK) == 32'h0000_0000)
        else $error("undefined line driven");

    // Pads follow the owner one cycle later; flags need a real change
    AST_PAD_DATA: assert property (1'b1 |=>
        ((pin_data_out & $past(owner_reg)) == $past(data_reg & owner_reg)))
        else $error("pad data does not follow data status");
    AST_PERIPH_OE: assert property (1'b1 |=>
        ((~pin_oe_n_out & ~$past(owner_reg) & LINE_MASK) == $past(periph_oe_in & ~owner_reg & LINE_MASK)))
        else $error("peripheral line not driven by the peripheral");
    AST_ISR_CAUSE: assert property (1'b1 |=>
        ((isr_reg & ~$past(isr_reg) & ~$past(change)) == 32'h0000_0000))
        else $error("change flag set with no input change");

    // Main scenarios the bench is expected to reach
    COV_ISR_READ: cover property (((isr_reg != 32'h0000_0000) && rd_irq_sts) ##1 (reg_rdata_out != 32'h0000_0000));
    COV_OWNER_SWAP: cover property (wr_owner_clr ##1 wr_owner_set);
    COV_DIRECT_WRITE: cover property (wr_data_dir && (permit_reg != 32'h0000_0000));
    COV_IRQ: cover property ($rose(irq_out));
    COV_PERIPH_DRIVE: cover property ((~owner_reg & periph_oe_in & LINE_MASK) != 32'h0000_0000);

endmodule // ilc_bank

/* tb/ilc_pad_model.sv */
// Pad and peripheral model facing the I/O line control bank
`timescale 1ns/1ps
module ilc_pad_model (
    // Pad drive from the bank
    input wire ilc_pkg::ilc_word_t pin_data_in,
    input wire ilc_pkg::ilc_word_t pin_oe_n_in,
    // Level forced by outside circuitry on undriven pads
    input wire ilc_pkg::ilc_word_t ext_level_in,
    // Resolved pad level and peripheral drive
    output ilc_pkg::ilc_word_t pad_level_out,
    output ilc_pkg::ilc_word_t periph_data_out,
    output ilc_pkg::ilc_word_t periph_oe_out
);
    import ilc_pkg::*;
    // Peripheral drives only part of its lines, so enable and data differ per bit
    localparam ilc_word_t PERIPH_OE = 32'h0000_0005;
    localparam ilc_word_t PERIPH_DATA = 32'h0000_000A;
    assign periph_oe_out = PERIPH_OE;
    assign periph_data_out = PERIPH_DATA;
    // Bank wins where its active-low enable is 0, outside level elsewhere
    assign pad_level_out = (~pin_oe_n_in & pin_data_in) | (pin_oe_n_in & ext_level_in);
endmodule // ilc_pad_model

/* tb/ilc_bank_test.sv */
// Self-checking bench for the I/O line control bank
`timescale 1ns/1ps
`include "ilc_defs.svh"
module ilc_bank_test;
    import ilc_pkg::*;
    // Line 31 left undefined so masked bits get exercised
    localparam ilc_word_t M = 32'h7FFF_FFFF;
    localparam ilc_word_t P = 32'h8000_A5C3;
    localparam ilc_word_t Q = 32'h0000_0481;
    localparam ilc_word_t ONES = `ILC_WORD_ONES;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ilc_addr_t reg_addr = 8'h00;
    ilc_word_t reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    ilc_word_t ext_level = 32'h0000_0000;
    ilc_word_t rdata, pin_data, pin_oe_n, periph_level, pad_level, periph_data, periph_oe;
    logic irq;
    int errors = 0;
    int num_checks = 0;
    ilc_addr_t rows [5][3] = '{'{`ILC_OFF_OWNER_SET, `ILC_OFF_OWNER_CLR, `ILC_OFF_OWNER_STS},
        '{`ILC_OFF_OE_SET, `ILC_OFF_OE_CLR, `ILC_OFF_OE_STS},
        '{`ILC_OFF_FILT_SET, `ILC_OFF_FILT_CLR, `ILC_OFF_FILT_STS},
        '{`ILC_OFF_DATA_SET, `ILC_OFF_DATA_CLR, `ILC_OFF_DATA_STS},
        '{`ILC_OFF_IRQ_SET, `ILC_OFF_IRQ_CLR, `ILC_OFF_IRQ_MASK}};

    // 250 MHz system clock
    always #2 sys_clk = ~sys_clk;

    ilc_bank #(.LINE_MASK(M), .OWNER_RESET(`ILC_OWNER_RESET)) dut (
        .sys_clk_in(sys_clk), .rst_in(rst), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .pin_level_in(pad_level),
        .pin_data_out(pin_data), .pin_oe_n_out(pin_oe_n), .periph_data_in(periph_data),
        .periph_oe_in(periph_oe), .periph_level_out(periph_level), .irq_out(irq));

    ilc_pad_model pads (.pin_data_in(pin_data), .pin_oe_n_in(pin_oe_n), .ext_level_in(ext_level),
        .pad_level_out(pad_level), .periph_data_out(periph_data), .periph_oe_out(periph_oe));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input ilc_word_t seen, input ilc_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input ilc_addr_t a, input ilc_word_t d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input ilc_addr_t a, input ilc_word_t e, input bit c);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        if (c) chk(rdata, e);
    endtask

    // Outside level stays for n edges then returns
    task automatic pulse(input ilc_word_t b, input int n);
        @(posedge sys_clk);
        ext_level <= ext_level ^ b;
        repeat (n) @(posedge sys_clk);
        ext_level <= ext_level ^ b;
        repeat (12) @(posedge sys_clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard: well above the length of the sequence
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("ERROR at %0t: run limit reached", $time);
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (15) @(posedge sys_clk);
        #1;
        chk(pin_oe_n, ONES);
        chk(periph_level, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Release on the sixteenth edge, like every other input change
        @(posedge sys_clk);
        rst <= 1'b0;
        rd(`ILC_OFF_OWNER_STS, `ILC_OWNER_RESET & M, 1);
        rd(`ILC_OFF_OE_STS, 32'h0, 1);
        rd(`ILC_OFF_FILT_STS, 32'h0, 1);
        rd(`ILC_OFF_IRQ_MASK, 32'h0, 1);
        rd(8'h0C, 32'h0, 1);
        rd(`ILC_OFF_OE_SET, 32'h0, 1);
        $display("reset test done");

        // Set, clear and no-effect writes for the ownership, output-enable, filter, data and irq mask groups
        foreach (rows[i]) begin
            wr(rows[i][1], ONES);
            rd(rows[i][2], 32'h0, 1);
            wr(rows[i][0], P);
            rd(rows[i][2], P & M, 1);
            wr(rows[i][1], Q);
            rd(rows[i][2], P & ~Q & M, 1);
            wr(rows[i][0], 32'h0);
            rd(rows[i][2], P & ~Q & M, 1);
        end
        wr(`ILC_OFF_OE_STS, ONES);
        rd(`ILC_OFF_OE_STS, P & ~Q & M, 1);
        $display("table test done");

        // Controller-owned drive and live pad levels
        wr(`ILC_OFF_OWNER_SET, ONES);
        wr(`ILC_OFF_OE_CLR, ONES);
        wr(`ILC_OFF_DATA_CLR, ONES);
        wr(`ILC_OFF_IRQ_CLR, ONES);
        wr(`ILC_OFF_FILT_CLR, ONES);
        wr(`ILC_OFF_OE_SET, 32'h0000_00FF);
        wr(`ILC_OFF_DATA_SET, 32'h0000_0055);
        ext_level <= 32'hA5A5_0000;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(pin_oe_n, 32'hFFFF_FF00);
        chk(pin_data, 32'h0000_0055);
        repeat (10) @(posedge sys_clk);
        rd(`ILC_OFF_PIN_STS, 32'hA5A5_0055 & M, 1);
        chk(periph_level, 32'hA5A5_0055 & M);
        $display("drive test done");

        // Lines handed to the peripheral follow its drive
        wr(`ILC_OFF_OWNER_CLR, 32'h0000_000F);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(pin_oe_n & 32'hF, ~periph_oe & 32'hF);
        chk(pin_data & 32'hF, periph_data & 32'hF);
        rd(`ILC_OFF_OWNER_STS, 32'hFFFF_FFF0 & M, 1);
        $display("ownership test done");

        // Direct data write only where permitted
        wr(`ILC_OFF_DATA_STS, 32'h0000_00F0);
        rd(`ILC_OFF_DATA_STS, 32'h0000_0055, 1);
        wr(`ILC_OFF_PERMIT_SET, 32'h0000_00F0);
        wr(`ILC_OFF_DATA_STS, 32'h0000_00A0);
        rd(`ILC_OFF_DATA_STS, 32'h0000_00A5, 1);
        $display("permit test done");

        // Change interrupt raised, cleared by read, then masked
        wr(`ILC_OFF_IRQ_SET, 32'h0010_0000);
        rd(`ILC_OFF_IRQ_MASK, 32'h0010_0000, 1);
        rd(`ILC_OFF_IRQ_STS, 32'h0, 0);
        @(posedge sys_clk);
        ext_level <= ext_level ^ 32'h0010_0000;
        for (int i = 0; i < 30 && irq !== 1'b1; i++) @(posedge sys_clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        rd(`ILC_OFF_IRQ_STS, 32'h0010_0000, 1);
        chk({31'h0, irq}, 32'h0);
        rd(`ILC_OFF_IRQ_STS, 32'h0, 1);
        wr(`ILC_OFF_IRQ_CLR, 32'h0010_0000);
        pulse(32'h0010_0000, 4);
        chk({31'h0, irq}, 32'h0);
        rd(`ILC_OFF_IRQ_STS, 32'h0010_0000, 1);
        $display("interrupt test done");

        // Two-sample pulse: blocked with filter, seen without
        wr(`ILC_OFF_FILT_SET, 32'h0020_0000);
        rd(`ILC_OFF_FILT_STS, 32'h0020_0000, 1);
        rd(`ILC_OFF_IRQ_STS, 32'h0, 0);
        pulse(32'h0020_0000, 2);
        rd(`ILC_OFF_IRQ_STS, 32'h0, 1);
        wr(`ILC_OFF_FILT_CLR, 32'h0020_0000);
        pulse(32'h0020_0000, 2);
        rd(`ILC_OFF_IRQ_STS, 32'h0020_0000, 1);
        $display("filter test done");

        // Reset in mid-run returns every state to its reset value
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(pin_oe_n, ONES);
        chk(pin_data, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
        rd(`ILC_OFF_OWNER_STS, `ILC_OWNER_RESET & M, 1);
        rd(`ILC_OFF_OE_STS, 32'h0, 1);
        rd(`ILC_OFF_DATA_STS, 32'h0, 1);
        $display("second reset test done");
        give_verdict();
    end
endmodule // ilc_bank_test
